// ==== logic/dadc_readout.sv ====
// dual converter conversion control and serial readout
// Functional notes
// - select falling edge samples and starts conversion
// - conversion paced only by serial clock
// - conversion finishes within 16 serial clocks
// - frame carries its own conversion, no delay
// - range at select fall sets span
// - both converters sample and finish together
// - each converter muxes two inputs
// - 12-bit results, every code reachable
// - 1 MSPS sustained at full serial clock
// - outputs advance after serial clock falls
// - outputs released after 32nd falling edge
// - low range binary, high two's complement
// - range change by 2nd edge flips coding
// - zero, three status, twelve bits, MSB first
// - further 16 clocks give other result
`timescale 1ns/1ps
`include "dadc_defines.svh"

module dadc_readout
	import dadc_pkg::*;
#(
	parameter int FIFO_DEPTH = `DADC_FIFO_DEPTH
)
(
	// system clock and reset
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	// serial link
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   range_sel,
	input  wire logic                   chan_sel,
	output      logic                   serial_out_first,
	output      logic                   serial_out_first_oe,
	output      logic                   serial_out_second,
	output      logic                   serial_out_second_oe,
	// quantised analog inputs, full scale is twice the reference
	input  wire logic [`DADC_AIN_W-1:0] ain_a1,
	input  wire logic [`DADC_AIN_W-1:0] ain_a2,
	input  wire logic [`DADC_AIN_W-1:0] ain_b1,
	input  wire logic [`DADC_AIN_W-1:0] ain_b2,
	// result log
	output      logic                   log_valid,
	input  wire logic                   log_ready,
	output      logic [`DADC_LOG_W-1:0] log_data
);

	// ---------------- system clock side ----------------
	logic                    cs_s;
	logic                    range_s;
	logic                    chan_s;
	logic                    tgl_s;
	logic                    tgl_d_ff;
	logic                    done_evt;
	dadc_code_t              hold_a_ff;
	dadc_code_t              hold_b_ff;
	logic [`DADC_STAT_W-1:0] hold_st_ff;
	dadc_code_t              nxt_hold_a;
	dadc_code_t              nxt_hold_b;
	logic [`DADC_STAT_W-1:0] nxt_hold_st;
	dadc_push_e              push_ff;
	dadc_push_e              nxt_push;
	logic [`DADC_LOG_W-1:0]  pend_ff;
	logic [`DADC_LOG_W-1:0]  nxt_pend;
	logic                    fifo_in_ready;
	logic                    fifo_in_valid;

	// ---------------- link side ----------------
	logic                    frame_clr;
	logic [`DADC_CNT_W-1:0]  cnt_ff;
	logic [`DADC_CNT_W-1:0]  nxt_cnt;
	dadc_code_t              held_a_ff;
	dadc_code_t              held_b_ff;
	logic [`DADC_STAT_W-1:0] held_st_ff;
	dadc_code_t              nxt_held_a;
	dadc_code_t              nxt_held_b;
	logic [`DADC_STAT_W-1:0] nxt_held_st;
	dadc_code_t              appr_a_ff;
	dadc_code_t              appr_b_ff;
	dadc_code_t              nxt_appr_a;
	dadc_code_t              nxt_appr_b;
	logic                    twos_ff;
	logic                    nxt_twos;
	logic                    out_a_ff;
	logic                    out_b_ff;
	logic                    nxt_out_a;
	logic                    nxt_out_b;
	logic                    dec_a;
	logic                    dec_b;
	logic                    rng_l_s;
	dadc_code_t              res_a_ff;
	dadc_code_t              res_b_ff;
	logic [`DADC_STAT_W-1:0] res_st_ff;
	logic                    tgl_ff;
	dadc_code_t              nxt_res_a;
	dadc_code_t              nxt_res_b;
	logic [`DADC_STAT_W-1:0] nxt_res_st;
	logic                    nxt_tgl;

	// span folding: low range clips at one reference, high halves the input
	function automatic dadc_code_t span_code(input logic [`DADC_AIN_W-1:0] ain, input logic wide);
		dadc_code_t code;
		code = '0;
		if (wide)
			code = ain[`DADC_AIN_W-1:1];
		else if (ain > `DADC_FULL_SCALE)
			code = dadc_code_t'(`DADC_FULL_SCALE);
		else
			code = ain[`DADC_RES_W-1:0];
		return code;
	endfunction : span_code

	// one frame bit: leading zero, status, then result bits
	function automatic logic frame_bit(input logic [3:0] pos, input logic [`DADC_STAT_W-1:0] st,
		input dadc_code_t res);
		logic b;
		b = 1'b0;
		if (pos == `DADC_POS_ZERO)
			b = 1'b0;
		else if (pos < 4'(`DADC_POS_MSB))
			b = st[`DADC_STAT_W - 32'(pos)];
		else
			b = res[4'hF - pos];
		return b;
	endfunction : frame_bit

	dadc_sync #(.W(3), .RST_VAL(3'h4)) u_sync_pins
	(
		.clk   (mclk),
		.rst_n (arst_n),
		.d     ({cs_n, range_sel, chan_sel}),
		.q     ({cs_s, range_s, chan_s})
	);

	dadc_sync #(.W(1), .RST_VAL(1'h0)) u_sync_done
	(
		.clk   (mclk),
		.rst_n (arst_n),
		.d     (tgl_ff),
		.q     (tgl_s)
	);

	// track while idle, freeze once select is seen low; the link side copies
	// them at the first fall, so the host leaves three system clocks before it
	always_comb
	begin
		nxt_hold_a  = hold_a_ff;
		nxt_hold_b  = hold_b_ff;
		nxt_hold_st = hold_st_ff;
		if (cs_s)
		begin
			nxt_hold_a = span_code(chan_s ? ain_a2 : ain_a1, range_s);
			nxt_hold_b = span_code(chan_s ? ain_b2 : ain_b1, range_s);
			nxt_hold_st[`DADC_STAT_FULL]  = !fifo_in_ready;
			nxt_hold_st[`DADC_STAT_CHAN]  = chan_s;
			nxt_hold_st[`DADC_STAT_RANGE] = range_s;
		end
	end

	// log push waits for fifo space, stalling on back-pressure
	always_comb
	begin
		done_evt      = tgl_s ^ tgl_d_ff;
		nxt_push      = push_ff;
		nxt_pend      = pend_ff;
		fifo_in_valid = 1'b0;
		unique case (push_ff)
			DADC_PUSH_IDLE:
			begin
				if (done_evt)
				begin
					nxt_pend = {res_st_ff, res_a_ff, res_b_ff};
					nxt_push = DADC_PUSH_WAIT;
				end
			end
			DADC_PUSH_WAIT:
			begin
				fifo_in_valid = 1'b1;
				if (fifo_in_ready)
					nxt_push = DADC_PUSH_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_a_ff  <= '0;
			hold_b_ff  <= '0;
			hold_st_ff <= '0;
			tgl_d_ff   <= 1'b0;
			push_ff    <= DADC_PUSH_IDLE;
			pend_ff    <= '0;
		end
		else
		begin
			hold_a_ff  <= nxt_hold_a;
			hold_b_ff  <= nxt_hold_b;
			hold_st_ff <= nxt_hold_st;
			tgl_d_ff   <= tgl_s;
			push_ff    <= nxt_push;
			pend_ff    <= nxt_pend;
		end
	end

	dadc_fifo #(.W(`DADC_LOG_W), .DEPTH(FIFO_DEPTH)) u_log_fifo
	(
		.clk       (mclk),
		.rst_n     (arst_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (pend_ff),
		.out_valid (log_valid),
		.out_ready (log_ready),
		.out_data  (log_data)
	);

	// ---------------- link clock domain ----------------
	// select high clears the frame, so no edge is needed outside frames
	assign frame_clr = cs_n | !arst_n;

	// range is a pin: two falling-edge flops before the coding decision
	always_ff @(negedge sclk or posedge frame_clr)
	begin
		if (frame_clr)
		begin
			cnt_ff     <= '0;
			held_a_ff  <= '0;
			held_b_ff  <= '0;
			held_st_ff <= '0;
			appr_a_ff  <= '0;
			appr_b_ff  <= '0;
			twos_ff    <= 1'b0;
			out_a_ff   <= 1'b0;
			out_b_ff   <= 1'b0;
		end
		else
		begin
			cnt_ff     <= nxt_cnt;
			held_a_ff  <= nxt_held_a;
			held_b_ff  <= nxt_held_b;
			held_st_ff <= nxt_held_st;
			appr_a_ff  <= nxt_appr_a;
			appr_b_ff  <= nxt_appr_b;
			twos_ff    <= nxt_twos;
			out_a_ff   <= nxt_out_a;
			out_b_ff   <= nxt_out_b;
		end
	end

	dadc_sync #(.W(1), .RST_VAL(1'h0)) u_sync_range
	(
		.clk   (!sclk),
		.rst_n (arst_n),
		.d     (range_sel),
		.q     (rng_l_s)
	);

	always_comb
	begin
		nxt_cnt     = (cnt_ff == `DADC_FRAME_END) ? cnt_ff : cnt_ff + 6'h01;
		nxt_held_a  = held_a_ff;
		nxt_held_b  = held_b_ff;
		nxt_held_st = held_st_ff;
		nxt_appr_a  = appr_a_ff;
		nxt_appr_b  = appr_b_ff;
		nxt_twos    = twos_ff;
		dec_a       = 1'b0;
		dec_b       = 1'b0;
		if (nxt_cnt == `DADC_POS_LOAD)
		begin
			nxt_held_a  = hold_a_ff;
			nxt_held_b  = hold_b_ff;
			nxt_held_st = hold_st_ff;
		end
		if (nxt_cnt == `DADC_POS_MSB)
			nxt_twos = rng_l_s;
		if (nxt_cnt >= `DADC_POS_MSB && nxt_cnt <= `DADC_POS_LAST)
		begin
			dec_a = held_a_ff >= (appr_a_ff | (12'h800 >> (nxt_cnt - `DADC_POS_MSB)));
			dec_b = held_b_ff >= (appr_b_ff | (12'h800 >> (nxt_cnt - `DADC_POS_MSB)));
			if (dec_a)
				nxt_appr_a = appr_a_ff | (12'h800 >> (nxt_cnt - `DADC_POS_MSB));
			if (dec_b)
				nxt_appr_b = appr_b_ff | (12'h800 >> (nxt_cnt - `DADC_POS_MSB));
		end
	end

	// output bits change only on falling edges, or clear when select goes high or reset is asserted
	always_comb
	begin
		nxt_out_a = 1'b0;
		nxt_out_b = 1'b0;
		if (!nxt_cnt[4])
		begin
			nxt_out_a = frame_bit(nxt_cnt[3:0], nxt_held_st, nxt_appr_a);
			nxt_out_b = frame_bit(nxt_cnt[3:0], nxt_held_st, nxt_appr_b);
			if (nxt_cnt == `DADC_POS_MSB)
			begin
				nxt_out_a = nxt_out_a ^ nxt_twos;
				nxt_out_b = nxt_out_b ^ nxt_twos;
			end
		end
		else if (nxt_cnt != `DADC_FRAME_END)
		begin
			nxt_out_a = frame_bit(nxt_cnt[3:0], res_st_ff, res_b_ff);
			nxt_out_b = frame_bit(nxt_cnt[3:0], res_st_ff, res_a_ff);
		end
	end

	// finished results survive select going high for the log crossing
	always_comb
	begin
		nxt_res_a  = res_a_ff;
		nxt_res_b  = res_b_ff;
		nxt_res_st = res_st_ff;
		nxt_tgl    = tgl_ff;
		if (nxt_cnt == `DADC_POS_LAST)
		begin
			nxt_res_a  = {nxt_appr_a[11] ^ twos_ff, nxt_appr_a[10:0]};
			nxt_res_b  = {nxt_appr_b[11] ^ twos_ff, nxt_appr_b[10:0]};
			nxt_res_st = held_st_ff;
			nxt_tgl    = !tgl_ff;
		end
	end

	always_ff @(negedge sclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			res_a_ff  <= '0;
			res_b_ff  <= '0;
			res_st_ff <= '0;
			tgl_ff    <= 1'b0;
		end
		else
		begin
			res_a_ff  <= nxt_res_a;
			res_b_ff  <= nxt_res_b;
			res_st_ff <= nxt_res_st;
			tgl_ff    <= nxt_tgl;
		end
	end

	assign serial_out_first_oe  = !cs_n && arst_n && (cnt_ff != `DADC_FRAME_END);
	assign serial_out_second_oe = !cs_n && arst_n && (cnt_ff != `DADC_FRAME_END);
	assign serial_out_first     = out_a_ff;
	assign serial_out_second    = out_b_ff;

endmodule : dadc_readout

// ==== pkg/dadc_defines.svh ====
// constants for the dual converter serial readout
`ifndef DADC_DEFINES_SVH
`define DADC_DEFINES_SVH

`define DADC_RES_W        12
`define DADC_AIN_W        13
`define DADC_STAT_W       3
`define DADC_CNT_W        6
`define DADC_LOG_W        27
`define DADC_FIFO_DEPTH   32
`define DADC_POS_ZERO     4'h0
`define DADC_POS_LOAD     6'h01
`define DADC_POS_MSB      6'h04
`define DADC_POS_LAST     6'h0F
`define DADC_FRAME_END    6'h20
`define DADC_FULL_SCALE   13'h0FFF
`define DADC_STAT_FULL    2
`define DADC_STAT_CHAN    1
`define DADC_STAT_RANGE   0
`define DADC_CONV_SCLK    16
`define DADC_T_CONV_NS    800
`define DADC_T_QUIET_NS   200
`define DADC_MCLK_NS      50
`define DADC_QUIET_CYC    ((`DADC_T_QUIET_NS + `DADC_MCLK_NS - 1) / `DADC_MCLK_NS)

`endif

// ==== pkg/dadc_pkg.sv ====
// types for the dual converter serial readout
package dadc_pkg;

	typedef enum logic {
		DADC_PUSH_IDLE,
		DADC_PUSH_WAIT
	} dadc_push_e;

	typedef logic [11:0] dadc_code_t;

endpackage : dadc_pkg

// ==== logic/dadc_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps

module dadc_sync
	import dadc_pkg::*;
#(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// data
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= RST_VAL;
			q_ff    <= RST_VAL;
		end
		else
		begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule : dadc_sync

// ==== logic/dadc_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps

module dadc_fifo
	import dadc_pkg::*;
#(
	parameter int W     = 27,
	parameter int DEPTH = 32
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	output      logic         in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output      logic         out_valid,
	input  wire logic         out_ready,
	output      logic [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ff;
	logic [AW:0]  rd_ff;
	logic [AW:0]  nxt_wr;
	logic [AW:0]  nxt_rd;
	logic         do_wr;
	logic         do_rd;
	logic         full;
	logic         empty;

	always_comb
	begin
		empty  = (wr_ff == rd_ff);
		full   = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
		do_wr  = in_valid && !full;
		do_rd  = out_ready && !empty;
		nxt_wr = do_wr ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = do_rd ? rd_ff + 1'b1 : rd_ff;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
		end
		else
		begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge clk)
	begin
		if (do_wr)
		begin
			mem[wr_ff[AW-1:0]] <= in_data;
		end
	end

	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ff[AW-1:0]];

endmodule : dadc_fifo

// ==== verification/dadc_host.sv ====
// host model: select, gated serial clock, reads both lines
`timescale 1ns/1ps

module dadc_host
	import dadc_pkg::*;
(
	// link out
	output logic      sclk,
	output logic      cs_n,
	// lines in
	input  wire logic mclk,
	input  wire logic d_first,
	input  wire logic oe_first,
	input  wire logic d_second,
	input  wire logic oe_second
);
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
	end

	task automatic frame(input int n, output logic [31:0] wa, output logic [31:0] wb, output logic [1:0] rel);
		wa = '1;
		wb = '1;
		@(posedge mclk);
		cs_n <= 1'b0;
		// select must reach the freeze before the first fall copies the words
		repeat (3) @(posedge mclk);
		for (int i = 0; i < n; i++)
		begin
			// even duty, clock only in frame
			#62.5;
			wa[31-i] = oe_first ? d_first : 1'bz;
			wb[31-i] = oe_second ? d_second : 1'bz;
			sclk = 1'b0;
			#62.5;
			sclk = 1'b1;
		end
		#62.5;
		rel = {oe_first, oe_second};
		@(posedge mclk);
		cs_n <= 1'b1;
		// quiet gap, also lets the freeze re-track
		repeat (5) @(posedge mclk);
	endtask : frame
endmodule : dadc_host

// ==== verification/dadc_readout_sva.sv ====
// assertions on the serial readout ports
`timescale 1ns/1ps
`include "dadc_defines.svh"

module dadc_readout_sva
	import dadc_pkg::*;
#(
	parameter int FIFO_DEPTH = `DADC_FIFO_DEPTH
)
(
	// clocks and reset
	input wire logic                   mclk,
	input wire logic                   arst_n,
	input wire logic                   sclk,
	// link
	input wire logic                   cs_n,
	input wire logic                   serial_out_first,
	input wire logic                   serial_out_first_oe,
	input wire logic                   serial_out_second,
	input wire logic                   serial_out_second_oe,
	// log
	input wire logic                   log_valid,
	input wire logic                   log_ready,
	input wire logic [`DADC_LOG_W-1:0] log_data
);
	logic [5:0] fall_cnt_ff;
	logic [5:0] nxt_fall_cnt;

	// saturates so edges past the frame stay visible
	always_comb
		nxt_fall_cnt = (fall_cnt_ff == 6'h3F) ? fall_cnt_ff : fall_cnt_ff + 6'h01;

	always_ff @(negedge sclk or posedge cs_n)
		if (cs_n)
			fall_cnt_ff <= 6'h00;
		else
			fall_cnt_ff <= nxt_fall_cnt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_idle_lines_free: assert property (cs_n |-> !serial_out_first_oe && !serial_out_second_oe)
		else $error("line driven while idle");
	a_enable_pair: assert property (serial_out_first_oe == serial_out_second_oe)
		else $error("enables differ");
	a_frame_driven: assert property (!cs_n && fall_cnt_ff < 6'h20 |-> serial_out_first_oe)
		else $error("line not driven in frame");
	a_release_last: assert property (fall_cnt_ff >= 6'h20 |-> !serial_out_first_oe && !serial_out_second_oe)
		else $error("line held after last edge");
	a_lead_zero: assert property (!cs_n && (fall_cnt_ff == 6'h00 || fall_cnt_ff == 6'h10)
		|-> !serial_out_first && !serial_out_second)
		else $error("leading bit not zero");
	a_status_both: assert property (!cs_n && fall_cnt_ff inside {[1:3], [17:19]}
		|-> serial_out_first == serial_out_second)
		else $error("status differs between lines");
	a_bit_held: assert property (!cs_n && $past(!cs_n) && sclk == $past(sclk)
		|-> $stable(serial_out_first) && $stable(serial_out_second))
		else $error("bit moved without falling edge");
	a_log_word_held: assert property (log_valid && !log_ready |=> log_valid && $stable(log_data))
		else $error("log word lost before accept");

	c_frame_start: cover property ($fell(cs_n));
	c_long_frame: cover property (fall_cnt_ff == 6'h20);
	c_log_pop: cover property (log_valid && log_ready);
endmodule : dadc_readout_sva

bind dadc_readout dadc_readout_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
	.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
	.serial_out_first(serial_out_first), .serial_out_first_oe(serial_out_first_oe),
	.serial_out_second(serial_out_second), .serial_out_second_oe(serial_out_second_oe),
	.log_valid(log_valid), .log_ready(log_ready), .log_data(log_data));

// ==== verification/test_dadc_readout.sv ====
// self-checking bench for the dual converter serial readout
`timescale 1ns/1ps
`include "dadc_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("wrong value t=%0t got %h exp %h", $time, a, b); end end

module test_dadc_readout
	import dadc_pkg::*;
;
	logic                   mclk, arst_n, range_sel, chan_sel, log_ready;
	logic                   sclk, cs_n, d_a, oe_a, d_b, oe_b, log_valid;
	logic [`DADC_AIN_W-1:0] ain_a1, ain_a2, ain_b1, ain_b2;
	logic [`DADC_LOG_W-1:0] log_data;
	int                     miscompares, check_count;
	int                     cycles = 0;

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	dadc_readout #(.FIFO_DEPTH(`DADC_FIFO_DEPTH)) DUT (
		.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .range_sel(range_sel), .chan_sel(chan_sel),
		.serial_out_first(d_a), .serial_out_first_oe(oe_a), .serial_out_second(d_b), .serial_out_second_oe(oe_b),
		.ain_a1(ain_a1), .ain_a2(ain_a2), .ain_b1(ain_b1), .ain_b2(ain_b2),
		.log_valid(log_valid), .log_ready(log_ready), .log_data(log_data));

	dadc_host host (.sclk(sclk), .cs_n(cs_n), .mclk(mclk), .d_first(d_a), .oe_first(oe_a),
		.d_second(d_b), .oe_second(oe_b));

	// low span clips above full scale, high span halves
	function automatic dadc_code_t span(input logic [12:0] ain, input logic rng);
		if (rng)
			return ain[12:1];
		return (ain > `DADC_FULL_SCALE) ? 12'hFFF : ain[11:0];
	endfunction : span

	task automatic one_frame(input int n, input logic flip, input logic full, input logic drain);
		dadc_code_t  ca, cb;
		logic [15:0] xa, xb;
		logic [31:0] wa, wb;
		logic [1:0]  rel;
		int          k;
		ca = span(chan_sel ? ain_a2 : ain_a1, range_sel);
		cb = span(chan_sel ? ain_b2 : ain_b1, range_sel);
		ca[11] = ca[11] ^ range_sel ^ flip;
		cb[11] = cb[11] ^ range_sel ^ flip;
		xa = {1'b0, full, chan_sel, range_sel, ca};
		xb = {1'b0, full, chan_sel, range_sel, cb};
		fork
			host.frame(n, wa, wb, rel);
			if (flip)
			begin
				@(negedge cs_n);
				repeat (4) @(posedge mclk);
				range_sel <= ~range_sel;
			end
		join
		`CHK(wa[31:16], xa)
		`CHK(wb[31:16], xb)
		if (n == 32)
		begin
			`CHK(wa[15:0], xb)
			`CHK(wb[15:0], xa)
			`CHK(rel, 2'b00)
		end
		if (drain)
		begin
			k = 0;
			do
			begin
				@(posedge mclk);
				k++;
			end
			while (log_valid !== 1'b1 && k < 20);
			`CHK(log_data, {xa[14:12], ca, cb})
			log_ready <= 1'b1;
			@(posedge mclk);
			log_ready <= 1'b0;
		end
	endtask : one_frame

	task automatic t_codes;
		for (int i = 0; i < 4; i++)
		begin
			{range_sel, chan_sel} <= i[1:0];
			@(posedge mclk);
			one_frame(32, 1'b0, 1'b0, 1'b1);
		end
		$display("span and channel test done");
	endtask : t_codes

	task automatic t_flip;
		for (int i = 0; i < 2; i++)
		begin
			range_sel <= i[0];
			@(posedge mclk);
			one_frame(16, 1'b1, 1'b0, 1'b1);
		end
		$display("coding switch test done");
	endtask : t_flip

	task automatic t_fill;
		int got;
		got = 0;
		for (int i = 0; i < `DADC_FIFO_DEPTH; i++)
			one_frame(16, 1'b0, 1'b0, 1'b0);
		one_frame(16, 1'b0, 1'b1, 1'b0);
		log_ready <= 1'b1;
		repeat (40)
		begin
			@(posedge mclk);
			got += (log_valid === 1'b1);
		end
		log_ready <= 1'b0;
		`CHK(got, `DADC_FIFO_DEPTH + 1)
		`CHK(log_valid, 1'b0)
		$display("log fill test done");
	endtask : t_fill

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	// cut a hang short
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			miscompares++;
			summarize;
		end
	end

	initial
	begin
		miscompares = 0;
		check_count = 0;
		arst_n = 1'b0;
		range_sel = 1'b0;
		chan_sel = 1'b0;
		log_ready = 1'b0;
		ain_a1 = 13'h1FFF;
		ain_a2 = 13'h0800;
		ain_b1 = 13'h0001;
		ain_b2 = 13'h1000;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_codes;
		t_flip;
		t_fill;
		summarize;
	end
endmodule : test_dadc_readout
